// [verilog/fib_isp_ctrl.sv]
// Operation
// - option boot bit 0 (erased) starts the core in boot ROM after reset.
// - option boot bit 1 starts the core at flash address 0000.
// - boot ROM code watches the serial port and drives flash commands here.
// - boot ROM region spans 1K bytes, routine plus monitor code.
// - flash byte address is high register bits 15:8, low register bits 7:0.
// - both address registers clear to 00 on reset.
// - a flash read stores its byte in the read data register.
// - a write programs the write data register at the addressed location.
// - read and write data registers are reachable only from on-chip code.
// - write and erase pulse width comes from the pulse timing register.
// - a 24-bit key, LSB first, shifted in during reset is detected.
// - a valid key forces boot ROM start at 0000 regardless of boot bit.
// - supports byte read, write, page/mass erase, bursts, option read.
// - exit command resets the core; boot bit then picks flash or boot ROM.
// - boot source select is option bit 0: 1 flash, 0 boot ROM.
// - secured in boot ROM: reads give FF, writes and page erases refused.
// - mass erase allowed under security and clears the option byte.
//
// Local design decisions: the address-and-strobe port and the address map.
`include "fib_map.svh"

module fib_isp_ctrl
  import fib_pkg::*;
(
  input  wire logic                clk_sys_i,
  input  wire logic                sys_rst_i,
  input  wire logic                ext_rst_n_i,
  input  wire logic                forced_entry_data_pin_i,
  input  wire logic                forced_entry_clock_pin_i,
  input  wire logic [3:0]          reg_addr_i,
  input  wire logic [7:0]          reg_wdata_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  output logic      [7:0]          reg_rdata_o,
  input  wire logic [7:0]          option_byte_i,
  input  wire logic [7:0]          flash_rdata_i,
  output fib_pkg::fib_flash_req_t  flash_req_o,
  input  wire logic [15:0]         fetch_addr_i,
  output logic                     fetch_from_rom_o,
  output logic                     core_rst_o,
  output fib_pkg::fib_boot_t       boot_o
);
  import fib_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  fib_state_t  state_r;
  logic [7:0]  flash_addr_high_r;
  logic [7:0]  flash_addr_low_r;
  logic [7:0]  flash_read_byte_r;
  logic [7:0]  flash_write_byte_r;
  logic [7:0]  pulse_timing_reg_r;
  logic        timing_loaded_r;
  logic        refused_r;
  logic        auto_inc_r;
  logic [7:0]  option_r;
  logic [15:0] pulse_cnt_r;
  logic [7:0]  exit_cnt_r;
  logic        core_rst_r;
  logic        core_rst_prev_r;
  logic        forced_r;
  logic        key_match;
  logic        boot_rom;
  logic        secured;
  logic        ctl_wr;
  logic        op_go;
  logic        op_read;
  logic        op_write;
  logic        op_page;
  logic        op_mass;
  logic        op_exit;
  logic        pulse_ok;
  logic        pulse_done;
  logic [15:0] pulse_len;
  logic [15:0] flash_addr;
  logic        release_evt;

  assign flash_addr  = {flash_addr_high_r, flash_addr_low_r};
  assign boot_rom    = boot_o.from_rom;
  assign secured     = option_r[`FIB_OPT_SECURITY] && boot_rom;
  assign ctl_wr      = reg_wr_i && (reg_addr_i == `FIB_REG_CONTROL);
  assign op_go       = ctl_wr && (state_r == FIB_IDLE);
  assign op_read     = op_go && reg_wdata_i[`FIB_CTL_READ];
  assign op_write    = op_go && reg_wdata_i[`FIB_CTL_WRITE];
  assign op_page     = op_go && reg_wdata_i[`FIB_CTL_PAGE_ERASE];
  assign op_mass     = op_go && reg_wdata_i[`FIB_CTL_MASS_ERASE];
  assign op_exit     = op_go && reg_wdata_i[`FIB_CTL_EXIT];
  // refuse programming without timing, and byte writes and page erases under security
  assign pulse_ok    = timing_loaded_r &&
                       (op_mass || !secured);
  assign pulse_len   = ({8'h00, pulse_timing_reg_r} + 16'h0001) *
                       16'(`FIB_PULSE_UNIT_CYC);
  assign pulse_done  = (pulse_cnt_r == 16'h0001);
  assign release_evt = core_rst_prev_r && !core_rst_r;

  // ---------------------------------------------------------------
  // forced boot ROM entry
  // ---------------------------------------------------------------
  fib_key_det u_key_det (
    .clk_sys_i  (clk_sys_i),
    .sys_rst_i  (sys_rst_i),
    .arm_i      (!ext_rst_n_i),
    .key_data_i (forced_entry_data_pin_i),
    .key_clk_i  (forced_entry_clock_pin_i),
    .match_o    (key_match)
  );

  // a match is held until the core leaves reset and consumes it
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      forced_r <= 1'b0;
    end else if (key_match) begin
      forced_r <= 1'b1;
    end else if (release_evt) begin
      forced_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // core reset and boot source selection
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      core_rst_r      <= 1'b1;
      core_rst_prev_r <= 1'b1;
    end else begin
      core_rst_r      <= !ext_rst_n_i || (state_r == FIB_EXIT);
      core_rst_prev_r <= core_rst_r;
    end
  end
  assign core_rst_o = core_rst_r;

  // option byte is sampled while the core is held in reset so a
  // byte reprogrammed by the previous session takes effect now
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      option_r <= `FIB_ZERO_BYTE;
    end else if (state_r == FIB_PULSE && pulse_done &&
                 flash_req_o.mass_erase) begin
      option_r <= `FIB_ZERO_BYTE;
    end else if (core_rst_r) begin
      option_r <= option_byte_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      boot_o.from_rom <= 1'b1;
      boot_o.forced   <= 1'b0;
      boot_o.vector   <= `FIB_RESET_VECTOR;
    end else if (release_evt) begin
      // erased option reads 0 and lands in boot ROM
      boot_o.from_rom <= forced_r ||
                         !option_r[`FIB_OPT_BOOT_SRC];
      boot_o.forced   <= forced_r;
      boot_o.vector   <= `FIB_RESET_VECTOR;
    end
  end

  // boot ROM answers only the low 1K of the fetch space
  assign fetch_from_rom_o = boot_rom &&
                            ({1'b0, fetch_addr_i} < `FIB_BOOT_ROM_BYTES);

  // ---------------------------------------------------------------
  // address registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      flash_addr_high_r <= `FIB_ADDR_RST;
      flash_addr_low_r  <= `FIB_ADDR_RST;
    end else if (auto_inc_r && state_r == FIB_READ_CAP ||
                 auto_inc_r && state_r == FIB_PULSE && pulse_done &&
                 flash_req_o.wr) begin
      {flash_addr_high_r, flash_addr_low_r} <= flash_addr + 16'h0001;
    end else if (reg_wr_i && state_r == FIB_IDLE) begin
      // held during an operation so a stray write cannot move it
      if (reg_addr_i == `FIB_REG_ADDR_HIGH) begin
        flash_addr_high_r <= reg_wdata_i;
      end
      if (reg_addr_i == `FIB_REG_ADDR_LOW) begin
        flash_addr_low_r <= reg_wdata_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // data and timing registers (on-chip port only)
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reg_wr_i && reg_addr_i == `FIB_REG_WRITE_BYTE) begin
      flash_write_byte_r <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (state_r == FIB_READ_CAP) begin
      flash_read_byte_r <= secured ? `FIB_READ_SECURED
                                   : flash_rdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pulse_timing_reg_r <= `FIB_PULSE_RST;
      timing_loaded_r    <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == `FIB_REG_PULSE_TIMING &&
                 state_r == FIB_IDLE) begin
      pulse_timing_reg_r <= reg_wdata_i;
      timing_loaded_r    <= 1'b1;
    end
  end

  // refusal flag: set wins over the clear by a control write
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      refused_r <= 1'b0;
    end else if ((op_write || op_page || op_mass) && !pulse_ok) begin
      refused_r <= 1'b1;
    end else if (ctl_wr) begin
      refused_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // operation sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_r     <= FIB_IDLE;
      pulse_cnt_r <= 16'h0000;
      exit_cnt_r  <= 8'h00;
      auto_inc_r  <= 1'b0;
      flash_req_o <= '0;
    end else begin
      unique case (state_r)
        FIB_IDLE: begin
          flash_req_o.addr  <= flash_addr;
          flash_req_o.wdata <= flash_write_byte_r;
          auto_inc_r        <= reg_wdata_i[`FIB_CTL_AUTO_INC];
          // one command per write; exit outranks the rest
          if (op_exit) begin
            exit_cnt_r <= 8'(`FIB_EXIT_RST_CYC);
            state_r    <= FIB_EXIT;
          end else if (op_read) begin
            flash_req_o.rd <= 1'b1;
            state_r        <= FIB_READ;
          end else if ((op_write || op_page || op_mass) && pulse_ok) begin
            flash_req_o.mass_erase <= op_mass;
            flash_req_o.page_erase <= op_page && !op_mass;
            flash_req_o.wr         <= op_write && !op_page &&
                                      !op_mass;
            pulse_cnt_r            <= pulse_len;
            state_r                <= FIB_PULSE;
          end
        end
        FIB_READ: begin
          flash_req_o.rd <= 1'b0;
          state_r        <= FIB_READ_CAP;
        end
        FIB_READ_CAP: begin
          state_r <= FIB_IDLE;
        end
        FIB_PULSE: begin
          pulse_cnt_r <= pulse_cnt_r - 16'h0001;
          if (pulse_done) begin
            flash_req_o.wr         <= 1'b0;
            flash_req_o.page_erase <= 1'b0;
            flash_req_o.mass_erase <= 1'b0;
            state_r                <= FIB_IDLE;
          end
        end
        FIB_EXIT: begin
          exit_cnt_r <= exit_cnt_r - 8'h01;
          if (exit_cnt_r == 8'h01) begin
            state_r <= FIB_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= `FIB_ZERO_BYTE;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `FIB_REG_ADDR_HIGH:    reg_rdata_o <= flash_addr_high_r;
        `FIB_REG_ADDR_LOW:     reg_rdata_o <= flash_addr_low_r;
        `FIB_REG_READ_BYTE:    reg_rdata_o <= flash_read_byte_r;
        `FIB_REG_WRITE_BYTE:   reg_rdata_o <= flash_write_byte_r;
        `FIB_REG_PULSE_TIMING: reg_rdata_o <= pulse_timing_reg_r;
        `FIB_REG_STATUS: begin
          reg_rdata_o <= `FIB_ZERO_BYTE;
          reg_rdata_o[`FIB_STS_BUSY]      <= (state_r != FIB_IDLE);
          reg_rdata_o[`FIB_STS_REFUSED]   <= refused_r;
          reg_rdata_o[`FIB_STS_TIMING_OK] <= timing_loaded_r;
          reg_rdata_o[`FIB_STS_BOOT_ROM]  <= boot_rom;
          reg_rdata_o[`FIB_STS_FORCED]    <= boot_o.forced;
        end
        `FIB_REG_OPTION:       reg_rdata_o <= option_r;
        default:               reg_rdata_o <= `FIB_ZERO_BYTE;
      endcase
    end
  end

endmodule : fib_isp_ctrl

// [verilog/fib_map.svh]
`ifndef FIB_MAP_SVH
`define FIB_MAP_SVH

// register indices on the plain register port
`define FIB_REG_ADDR_HIGH    4'h0
`define FIB_REG_ADDR_LOW     4'h1
`define FIB_REG_READ_BYTE    4'h2
`define FIB_REG_WRITE_BYTE   4'h3
`define FIB_REG_PULSE_TIMING 4'h4
`define FIB_REG_CONTROL      4'h5
`define FIB_REG_STATUS       4'h6
`define FIB_REG_OPTION       4'h7

// control register command bits
`define FIB_CTL_READ         0
`define FIB_CTL_WRITE        1
`define FIB_CTL_PAGE_ERASE   2
`define FIB_CTL_MASS_ERASE   3
`define FIB_CTL_EXIT         4
`define FIB_CTL_AUTO_INC     5

// status register bits
`define FIB_STS_BUSY         0
`define FIB_STS_REFUSED      1
`define FIB_STS_TIMING_OK    2
`define FIB_STS_BOOT_ROM     3
`define FIB_STS_FORCED       4

// option byte fields
`define FIB_OPT_BOOT_SRC     0
`define FIB_OPT_SECURITY     5

// reset and fixed values
`define FIB_ADDR_RST         8'h00
`define FIB_PULSE_RST        8'h00
`define FIB_READ_SECURED     8'hFF
`define FIB_ZERO_BYTE        8'h00
`define FIB_RESET_VECTOR     16'h0000
`define FIB_BOOT_ROM_BYTES   17'h00400

// forced-entry key, shifted least significant bit first
`define FIB_KEY_VALUE        24'h5E38AC
`define FIB_KEY_BITS         5'd24

// timing
`define FIB_CLK_MHZ          200
`define FIB_PULSE_UNIT_NS    40
`define FIB_PULSE_UNIT_CYC   ((`FIB_PULSE_UNIT_NS * `FIB_CLK_MHZ + 999) / 1000)
`define FIB_EXIT_RST_NS      100
`define FIB_EXIT_RST_CYC     ((`FIB_EXIT_RST_NS * `FIB_CLK_MHZ + 999) / 1000)

`endif

// [verilog/fib_pkg.sv]
package fib_pkg;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
    logic        page_erase;
    logic        mass_erase;
  } fib_flash_req_t;

  typedef struct packed {
    logic        from_rom;
    logic        forced;
    logic [15:0] vector;
  } fib_boot_t;

  typedef enum logic [2:0] {
    FIB_IDLE,
    FIB_READ,
    FIB_READ_CAP,
    FIB_PULSE,
    FIB_EXIT
  } fib_state_t;

endpackage : fib_pkg

// [verilog/fib_key_det.sv]
`include "fib_map.svh"

module fib_key_det (
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  input  wire logic arm_i,
  input  wire logic key_data_i,
  input  wire logic key_clk_i,
  output logic      match_o
);

  logic [23:0] shift_r;
  logic [4:0]  count_r;
  logic        key_clk_r;
  logic        rise;

  assign rise = key_clk_i & ~key_clk_r;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      // follow the pin so an idle-high clock gives no false edge
      key_clk_r <= key_clk_i;
    end else begin
      key_clk_r <= key_clk_i;
    end
  end

  // bits enter at the top so the first bit ends in bit 0
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || !arm_i) begin
      shift_r <= 24'h000000;
      count_r <= 5'h00;
    end else if (rise) begin
      shift_r <= {key_data_i, shift_r[23:1]};
      if (count_r != `FIB_KEY_BITS) begin
        count_r <= count_r + 5'h01;
      end
    end
  end

  // exact match of all 24 bits, only while armed
  assign match_o = arm_i && (count_r == `FIB_KEY_BITS) &&
                   (shift_r == `FIB_KEY_VALUE);

endmodule : fib_key_det

// [test/fib_isp_ctrl_assertions.sv]
module fib_isp_ctrl_assertions (
  input  wire logic                    clk_sys_i,
  input  wire logic                    sys_rst_i,
  input  wire logic [3:0]              reg_addr_i,
  input  wire logic [7:0]              reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic [7:0]              option_byte_i,
  input  wire fib_pkg::fib_flash_req_t flash_req_o,
  input  wire logic [15:0]             fetch_addr_i,
  input  wire logic                    fetch_from_rom_o,
  input  wire logic                    core_rst_o,
  input  wire fib_pkg::fib_boot_t      boot_o
);
  import fib_pkg::*;
  // ---------------------------------------------
  // shadows of what software loaded
  // ---------------------------------------------
  logic [15:0] addr_s;
  logic [7:0]  wb_s;
  logic [7:0]  pt_s;
  logic        pt_ok;
  logic [11:0] wcnt;
  logic        pulse;
  assign pulse = flash_req_o.wr | flash_req_o.page_erase
               | flash_req_o.mass_erase;
  // writes while busy are never issued by the bench, so no busy tracking
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      addr_s <= 16'h0000;
      pt_ok  <= 1'b0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == 4'h0) addr_s[15:8] <= reg_wdata_i;
      if (reg_addr_i == 4'h1) addr_s[7:0] <= reg_wdata_i;
      if (reg_addr_i == 4'h3) wb_s <= reg_wdata_i;
      if (reg_addr_i == 4'h4) pt_s <= reg_wdata_i;
      if (reg_addr_i == 4'h4) pt_ok <= 1'b1;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    wcnt <= pulse ? wcnt + 12'h001 : 12'h000;
  end
  // ---------------------------------------------
  // properties
  // ---------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_boot;
    $fell(core_rst_o);
  endsequence
  sequence s_exit;
    reg_wr_i && reg_addr_i == 4'h5 && reg_wdata_i[4];
  endsequence
  // the boot record is loaded one cycle after the core reset falls
  property p_boot_src;
    s_boot |=> boot_o.from_rom == (boot_o.forced | !option_byte_i[0]);
  endproperty
  a_boot_src: assert property (p_boot_src)
    else $error("boot source");
  property p_vector;
    s_boot |=> boot_o.vector == 16'h0000;
  endproperty
  a_vector: assert property (p_vector)
    else $error("boot vector");
  property p_forced;
    s_boot ##1 boot_o.forced |-> boot_o.from_rom;
  endproperty
  a_forced: assert property (p_forced)
    else $error("forced boot");
  property p_rom_win;
    !core_rst_o |->
      fetch_from_rom_o == (boot_o.from_rom && fetch_addr_i < 16'h0400);
  endproperty
  a_rom_win: assert property (p_rom_win)
    else $error("rom window");
  property p_exit;
    s_exit |-> ##[1:3] core_rst_o;
  endproperty
  a_exit: assert property (p_exit)
    else $error("exit reset");
  property p_rd_addr;
    $rose(flash_req_o.rd) |-> flash_req_o.addr == addr_s ##1 !flash_req_o.rd;
  endproperty
  a_rd_addr: assert property (p_rd_addr)
    else $error("read address");
  property p_wdata;
    $rose(flash_req_o.wr) |->
      flash_req_o.wdata == wb_s && flash_req_o.addr == addr_s;
  endproperty
  a_wdata: assert property (p_wdata)
    else $error("write byte");
  property p_width;
    $fell(pulse) |-> wcnt == ({4'h0, pt_s} + 12'h001) << 3;
  endproperty
  a_width: assert property (p_width)
    else $error("pulse width");
  property p_untimed;
    !pt_ok |-> !pulse;
  endproperty
  a_untimed: assert property (p_untimed)
    else $error("untimed pulse");
  property p_secure;
    option_byte_i[5] && boot_o.from_rom && !core_rst_o |->
      !$rose(flash_req_o.wr) && !$rose(flash_req_o.page_erase);
  endproperty
  a_secure: assert property (p_secure)
    else $error("secure write");
endmodule : fib_isp_ctrl_assertions

bind fib_isp_ctrl fib_isp_ctrl_assertions fib_isp_ctrl_assertions_inst (
  .clk_sys_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .option_byte_i, .flash_req_o, .fetch_addr_i, .fetch_from_rom_o,
  .core_rst_o, .boot_o);

// [test/fib_flash_model.sv]
module fib_flash_model (
  input  wire logic                    clk_sys_i,
  input  wire fib_pkg::fib_flash_req_t req_i,
  output logic [7:0]                   rdata_o,
  output logic [7:0]                   option_o
);
  import fib_pkg::*;
  // page size is not fixed by the device: plain default
  localparam int PAGE = 64;
  logic [7:0] mem [0:4095];
  logic       wr_q;
  logic       pe_q;
  logic       me_q;
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'h5A;
    mem[4095] = 8'h00;
  end
  assign option_o = mem[4095];
  // cells change only when a pulse ends, as a real array would
  always @(posedge clk_sys_i) begin
    rdata_o <= req_i.rd ? mem[req_i.addr[11:0]] : ~rdata_o;
    wr_q <= req_i.wr;
    pe_q <= req_i.page_erase;
    me_q <= req_i.mass_erase;
    if (wr_q && !req_i.wr) mem[req_i.addr[11:0]] <= req_i.wdata;
    if (pe_q && !req_i.page_erase) begin
      for (int i = 0; i < PAGE; i++)
        mem[{req_i.addr[11:6], 6'h00} + i] <= 8'h00;
    end
    if (me_q && !req_i.mass_erase) begin
      for (int i = 0; i < 4096; i++) mem[i] <= 8'h00;
    end
  end
endmodule : fib_flash_model

// [test/tb_fib_isp_ctrl.sv]
module tb_fib_isp_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import fib_pkg::*;
  logic           clk_sys_i = 1'b0;
  logic           sys_rst_i = 1'b1;
  logic           ext_rst_n = 1'b1;
  logic           key_d     = 1'b0;
  logic           key_c     = 1'b0;
  logic [3:0]     ra        = 4'h0;
  logic [7:0]     wd        = 8'h00;
  logic           we        = 1'b0;
  logic           re        = 1'b0;
  logic [15:0]    fetch     = 16'h03FF;
  logic [7:0]     rdat;
  logic [7:0]     opt;
  logic [7:0]     frd;
  logic           from_rom;
  logic           crst;
  fib_flash_req_t req;
  fib_boot_t      boot;
  int             miscompares = 0;
  int             comparisons = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  fib_isp_ctrl fib_isp_ctrl_inst (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ext_rst_n_i(ext_rst_n),
    .forced_entry_data_pin_i(key_d), .forced_entry_clock_pin_i(key_c),
    .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(we), .reg_rd_i(re),
    .reg_rdata_o(rdat), .option_byte_i(opt), .flash_rdata_i(frd),
    .flash_req_o(req), .fetch_addr_i(fetch), .fetch_from_rom_o(from_rom),
    .core_rst_o(crst), .boot_o(boot));
  fib_flash_model fib_flash_model_inst (
    .clk_sys_i(clk_sys_i), .req_i(req), .rdata_o(frd), .option_o(opt));
  // ---------------------------------------------
  // register port tasks
  // ---------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    ra <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk_sys_i);
    we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    ra <= a;
    re <= 1'b1;
    @(posedge clk_sys_i);
    re <= 1'b0;
    #1 d = rdat;
  endtask : rd
  task automatic rchk(input string n, input logic [3:0] a,
                      input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(n, e, d);
  endtask : rchk
  task automatic cmd(input logic [15:0] a, input logic [7:0] c);
    logic [7:0] s;
    wr(4'h0, a[15:8]);
    wr(4'h1, a[7:0]);
    wr(4'h5, c);
    s = 8'h01;
    // address stays put until busy drops; a stuck busy counts as failure
    for (int i = 0; i < 600 && s[0] !== 1'b0; i++) rd(4'h6, s);
    chk("idle", 8'h00, {7'h00, s[0]});
  endtask : cmd
  task automatic leave;
    wr(4'h5, 8'h10);
    repeat (3) @(posedge clk_sys_i);
    chk("core_rst", 8'h01, {7'h00, crst});
    repeat (27) @(posedge clk_sys_i);
  endtask : leave
  task automatic key(input logic [23:0] k);
    @(posedge clk_sys_i);
    ext_rst_n <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk_sys_i);
      key_d <= k[i];
      key_c <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      key_c <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
    end
    ext_rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
  endtask : key
  task automatic wrap_up;
    if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rchk("addr_high", 4'h0, 8'h00);
    rchk("addr_low", 4'h1, 8'h00);
    chk("from_rom", 8'h01, {7'h00, boot.from_rom});
    chk("rom_window", 8'h01, {7'h00, from_rom});
    rchk("status", 4'h6, 8'h08);
    cmd(16'h0123, 8'h02);
    rchk("status", 4'h6, 8'h0A);
    cmd(16'h0123, 8'h01);
    rchk("read_byte", 4'h2, 8'h79);
    wr(4'h4, 8'h00);
    rchk("status", 4'h6, 8'h0C);
    wr(4'h3, 8'hC3);
    cmd(16'h0123, 8'h02);
    cmd(16'h0123, 8'h01);
    rchk("written", 4'h2, 8'hC3);
    cmd(16'h0100, 8'h04);
    cmd(16'h0123, 8'h01);
    rchk("page_erased", 4'h2, 8'h00);
    // read with auto-increment: the address moves on by one
    cmd(16'h0140, 8'h21);
    rchk("page_edge", 4'h2, 8'h1A);
    rchk("burst_addr", 4'h1, 8'h41);
    cmd(16'h0FFF, 8'h01);
    rchk("option", 4'h2, 8'h00);
    // secure while in boot ROM: reads masked, writes refused
    wr(4'h3, 8'h20);
    cmd(16'h0FFF, 8'h02);
    leave();
    wr(4'h4, 8'h00);
    cmd(16'h0140, 8'h01);
    rchk("secure_read", 4'h2, 8'hFF);
    wr(4'h3, 8'h55);
    cmd(16'h0140, 8'h02);
    rchk("status", 4'h6, 8'h0E);
    @(posedge clk_sys_i);
    fetch <= 16'h0400;
    cmd(16'h0000, 8'h08);
    chk("rom_window", 8'h00, {7'h00, from_rom});
    rchk("option_shadow", 4'h7, 8'h00);
    rchk("status", 4'h6, 8'h0C);
    wr(4'h3, 8'h01);
    cmd(16'h0FFF, 8'h02);
    cmd(16'h0FFF, 8'h01);
    rchk("option", 4'h2, 8'h01);
    leave();
    chk("from_rom", 8'h00, {7'h00, boot.from_rom});
    key(24'h5E38AC);
    chk("forced", 8'h01, {7'h00, boot.forced});
    chk("from_rom", 8'h01, {7'h00, boot.from_rom});
    key(24'h5E38AD);
    chk("forced", 8'h00, {7'h00, boot.forced});
    chk("from_rom", 8'h00, {7'h00, boot.from_rom});
    wrap_up();
  end
endmodule : tb_fib_isp_ctrl
